// *** verilog/sws_sleep_wake_supply_monitor.sv ***
/*
 * sws_sleep_wake_supply_monitor: sleep/wake sequencer with the supply
 * monitor control registers, reached over an Avalon-MM slave.
 * assumes the cpu core runs on sys_clk_i, so its rising edge is every
 * clock edge and its falling edge is modelled as the next edge; the
 * wake interrupt and comparator inputs are synchronous to sys_clk_i.
 */
// Design decision made here: the Avalon-MM register port.
// Behaviour
// - a sleep-bit write raises halt_request straight away, with no further edge.
// - the cpu core samples halt_request each clock and stops between instructions.
// - the cpu core grants the halt at the first instruction boundary after the write.
// - after the grant, wait for the cpu falling edge, then raise power_down.
// - power_down turns off flash, fast oscillator, filter and bandgap.
// - any unmasked interrupt wakes; the global enable plays no part; here a set stop bit blocks the wake.
// - the wake interrupt is synchronised on a falling 32 kHz edge.
// - the next rising 32 kHz edge drops power_down.
// - the following rising 32 kHz edge samples both supply comparators.
// - the following falling 32 kHz edge drops halt_request; grant then drops.
// - wakeup from interrupt to cpu running takes 62.5 to 93.75 microseconds.
// - precise_reset_level picks 2.7/3/5 V range; code 11 disables the reset.
// - lvd_trip_select sets detect and flash levels; codes 000-011 reserved.
// - comparator register reads live lvd in bit 1, precise reset in bit 0.
// - monitor_duty_cycle sets monitor on-time: 1/128, 1/512, 1/32, 1/8.
// - sleep request is bit 3 of system_control_reg; one means sleep.
// - after wake the cpu runs the instruction after the sleep write first.
module sws_sleep_wake_supply_monitor #(
  parameter int SLOW_HALF_CYC = sws_pkg::SLOW_HALF_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave, byte addressed
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // cpu core handshake
  output logic             halt_request_o,
  input  wire logic        halt_grant_i,
  input  wire logic        wake_irq_i,
  // power domain controls
  output logic             power_down_line_o,
  output logic             flash_power_en_o,
  output logic             fast_osc_en_o,
  output logic             transient_filter_en_o,
  output logic             bandgap_en_o,
  output logic             monitor_on_o,
  // supply monitor
  input  wire logic        low_supply_flag_i,
  input  wire logic        precise_reset_flag_i,
  output logic      [1:0]  precise_reset_level_o,
  output logic      [2:0]  lvd_trip_select_o,
  output logic             precise_reset_req_o
);

  initial
  begin
    if (SLOW_HALF_CYC < 2)
      $error("sws: SLOW_HALF_CYC must be at least 2");
  end

  // ==========================================================================
  // helpers
  function automatic logic hits(input logic [11:0] addr, input logic [9:0] idx);
    hits = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // on-time mask: the monitor is on while the masked count is zero
  function automatic logic [8:0] duty_mask(input logic [1:0] code);
    case (code)
      2'h0:    duty_mask = 9'h07f; // 1/128
      2'h1:    duty_mask = 9'h1ff; // 1/512
      2'h2:    duty_mask = 9'h01f; // 1/32
      default: duty_mask = 9'h007; // 1/8
    endcase
  endfunction

  // ==========================================================================
  // slow clock edges
  logic slow_rise;
  logic slow_fall;

  sws_slow_tick #(
    .HALF_CYC (SLOW_HALF_CYC)
  ) u_slow_tick (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .rise_o    (slow_rise),
    .fall_o    (slow_fall)
  );

  // ==========================================================================
  // bus slave: one wait cycle, then the answer
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0]  sys_ctrl_q;
  logic [7:0]  sys_ctrl_d;
  logic [7:0]  lvl_ctrl_q;
  logic [7:0]  lvl_ctrl_d;
  logic [7:0]  duty_q;
  logic [7:0]  duty_d;
  logic [1:0]  cmp_q;
  logic [1:0]  cmp_d;
  logic [1:0]  wake_cmp_q;
  logic [1:0]  wake_cmp_d;
  logic        req;
  logic        wr_go;
  logic        sleep_set;
  logic        seq_done;

  sws_pkg::sws_state_t state_q;
  sws_pkg::sws_state_t state_d;

  assign req       = avs_read_i | avs_write_i;
  assign wr_go     = avs_write_i & ~wait_q & avs_byteenable_i[0];
  assign sleep_set = wr_go && hits(avs_address_i, sws_pkg::SYS_CTRL_IDX)
                     && avs_writedata_i[sws_pkg::SLEEP_BIT];

  // read mux, loaded in the wait cycle so data stands with waitrequest low
  always_comb
  begin
    wait_d  = ~(req & wait_q);
    rdata_d = rdata_q;
    if (avs_read_i && wait_q)
    begin
      rdata_d = 32'h0000_0000;
      if (hits(avs_address_i, sws_pkg::SYS_CTRL_IDX))
        rdata_d[7:0] = sys_ctrl_q;
      else if (hits(avs_address_i, sws_pkg::LVL_CTRL_IDX))
        rdata_d[7:0] = lvl_ctrl_q & sws_pkg::LVL_CTRL_MASK;
      else if (hits(avs_address_i, sws_pkg::CMP_STATE_IDX))
        rdata_d[1:0] = cmp_q;
      else if (hits(avs_address_i, sws_pkg::DUTY_TRIM_IDX))
        rdata_d[7:0] = duty_q & sws_pkg::DUTY_MASK;
      else if (hits(avs_address_i, sws_pkg::SEQ_STATUS_IDX))
        rdata_d[7:0] = {2'h0, wake_cmp_q, 4'(state_q)};
    end
  end

  // ==========================================================================
  // register writes; the sequencer clears the sleep bit once awake
  always_comb
  begin
    sys_ctrl_d = sys_ctrl_q;
    lvl_ctrl_d = lvl_ctrl_q;
    duty_d     = duty_q;
    if (wr_go && hits(avs_address_i, sws_pkg::SYS_CTRL_IDX))
    begin
      sys_ctrl_d[sws_pkg::SLEEP_BIT] = avs_writedata_i[sws_pkg::SLEEP_BIT];
      sys_ctrl_d[sws_pkg::STOP_BIT]  = avs_writedata_i[sws_pkg::STOP_BIT];
    end
    if (wr_go && hits(avs_address_i, sws_pkg::LVL_CTRL_IDX))
      lvl_ctrl_d = avs_writedata_i[7:0] & sws_pkg::LVL_CTRL_MASK;
    if (wr_go && hits(avs_address_i, sws_pkg::DUTY_TRIM_IDX))
      duty_d = avs_writedata_i[7:0] & sws_pkg::DUTY_MASK;
    // a sleep write in the same cycle wins over the hardware clear
    if (seq_done && !sleep_set)
      sys_ctrl_d[sws_pkg::SLEEP_BIT] = 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      wait_q     <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      sys_ctrl_q <= sws_pkg::SYS_CTRL_RST;
      lvl_ctrl_q <= sws_pkg::LVL_CTRL_RST;
      duty_q     <= sws_pkg::DUTY_TRIM_RST;
    end
    else
    begin
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      sys_ctrl_q <= sys_ctrl_d;
      lvl_ctrl_q <= lvl_ctrl_d;
      duty_q     <= duty_d;
    end
  end

  // ==========================================================================
  // sleep / wake sequencer
  logic halt_q;
  logic halt_d;
  logic pd_q;
  logic pd_d;
  logic en_q;
  logic en_d;
  logic stopped;

  assign stopped  = sys_ctrl_q[sws_pkg::STOP_BIT];
  assign seq_done = (state_q == sws_pkg::SWS_GRANT_DROP) && !halt_grant_i;

  always_comb
  begin
    state_d    = state_q;
    halt_d     = halt_q;
    pd_d       = pd_q;
    wake_cmp_d = wake_cmp_q;
    case (state_q)
      sws_pkg::SWS_RUN:
        if (sleep_set)
        begin
          halt_d  = 1'b1; // raised on the write's own edge
          state_d = sws_pkg::SWS_HALT_WAIT;
        end
      sws_pkg::SWS_HALT_WAIT:
        // the core stops at an instruction boundary and grants
        if (halt_grant_i)
          state_d = sws_pkg::SWS_PD_EDGE;
      sws_pkg::SWS_PD_EDGE:
      begin
        pd_d    = 1'b1; // falling cpu edge after the grant
        state_d = sws_pkg::SWS_ASLEEP;
      end
      sws_pkg::SWS_ASLEEP:
        // no global enable input exists: any unmasked request wakes unless the stop bit is set
        if (wake_irq_i && !stopped)
          state_d = sws_pkg::SWS_SYNC;
      sws_pkg::SWS_SYNC:
        if (slow_fall)
          state_d = sws_pkg::SWS_POWER_UP;
      sws_pkg::SWS_POWER_UP:
        if (slow_rise)
        begin
          pd_d    = 1'b0;
          state_d = sws_pkg::SWS_SAMPLE;
        end
      sws_pkg::SWS_SAMPLE:
        if (slow_rise)
        begin
          wake_cmp_d = {low_supply_flag_i, precise_reset_flag_i};
          state_d    = sws_pkg::SWS_RELEASE;
        end
      sws_pkg::SWS_RELEASE:
        if (slow_fall)
        begin
          halt_d  = 1'b0;
          state_d = sws_pkg::SWS_GRANT_DROP;
        end
      sws_pkg::SWS_GRANT_DROP:
        if (!halt_grant_i)
          state_d = sws_pkg::SWS_RUN;
      default:
      begin
        state_d = sws_pkg::SWS_RUN;
        halt_d  = 1'b0;
        pd_d    = 1'b0;
      end
    endcase
    en_d = ~pd_d; // own flop, so the enable pins see no gate
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q    <= sws_pkg::SWS_RUN;
      halt_q     <= 1'b0;
      pd_q       <= 1'b0;
      en_q       <= 1'b1;
      wake_cmp_q <= 2'h0;
    end
    else
    begin
      state_q    <= state_d;
      halt_q     <= halt_d;
      pd_q       <= pd_d;
      en_q       <= en_d;
      wake_cmp_q <= wake_cmp_d;
    end
  end

  // ==========================================================================
  // supply monitor: comparator readback, duty cycle, reset request
  logic [8:0] duty_cnt_q;
  logic [8:0] duty_cnt_d;
  logic       mon_on_q;
  logic       mon_on_d;
  logic       preq_q;
  logic       preq_d;
  logic [1:0] prl;

  assign prl = lvl_ctrl_q[sws_pkg::PRL_LSB +: 2];

  // duty counting only matters asleep; awake the monitor stays on
  always_comb
  begin
    cmp_d      = {low_supply_flag_i, precise_reset_flag_i}; // live
    duty_cnt_d = duty_cnt_q;
    if (slow_rise)
      duty_cnt_d = duty_cnt_q + 9'h001;
    mon_on_d = !pd_q
               || ((duty_cnt_q & duty_mask(duty_q[sws_pkg::DUTY_LSB +: 2])) == 9'h000);
    // code 11 keeps the comparator readable but never resets
    preq_d = precise_reset_flag_i && (prl != sws_pkg::PRL_OFF);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cmp_q      <= 2'h0;
      duty_cnt_q <= 9'h000;
      mon_on_q   <= 1'b1;
      preq_q     <= 1'b0;
    end
    else
    begin
      cmp_q      <= cmp_d;
      duty_cnt_q <= duty_cnt_d;
      mon_on_q   <= mon_on_d;
      preq_q     <= preq_d;
    end
  end

  // ==========================================================================
  // outputs, all straight from flip-flops
  assign avs_readdata_o        = rdata_q;
  assign avs_waitrequest_o     = wait_q;
  assign halt_request_o        = halt_q;
  assign power_down_line_o     = pd_q;
  assign flash_power_en_o      = en_q;
  assign fast_osc_en_o         = en_q;
  assign transient_filter_en_o = en_q;
  assign bandgap_en_o          = en_q;
  assign monitor_on_o          = mon_on_q;
  assign precise_reset_level_o = prl;
  assign lvd_trip_select_o     = lvl_ctrl_q[sws_pkg::LTS_LSB +: 3];
  assign precise_reset_req_o   = preq_q;

endmodule

// *** inc/sws_pkg.sv ***
/*
 * sws_pkg: register map, field positions, reset values, sequencer states
 * and timing counts of the sleep/wake supply-monitor block.
 * assumes a single 100 MHz system clock; the 32 kHz low-power clock is
 * rebuilt from it as enable pulses.
 */
package sws_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [9:0] SYS_CTRL_IDX   = 10'h0ff; // system_control_reg
  localparam logic [9:0] LVL_CTRL_IDX   = 10'h1e3; // supply_level_control
  localparam logic [9:0] CMP_STATE_IDX  = 10'h1e4; // supply_comparator_state
  localparam logic [9:0] DUTY_TRIM_IDX  = 10'h1eb; // monitor_duty_trim
  localparam logic [9:0] SEQ_STATUS_IDX = 10'h1f0; // sequencer status

  // ==========================================================================
  // field positions
  localparam int SLEEP_BIT    = 3;
  localparam int STOP_BIT     = 0;
  localparam int PRL_LSB      = 4;  // precise_reset_level [5:4]
  localparam int LTS_LSB      = 0;  // lvd_trip_select [2:0]
  localparam int CMP_LVD_BIT  = 1;
  localparam int CMP_PRECISE_RESET_FLAG_BIT = 0;
  localparam int DUTY_LSB     = 6;  // monitor_duty_cycle [7:6]

  // ==========================================================================
  // reset values and field codes
  localparam logic [7:0] SYS_CTRL_RST  = 8'h00;
  localparam logic [7:0] LVL_CTRL_RST  = 8'h00;
  localparam logic [7:0] DUTY_TRIM_RST = 8'h00;
  localparam logic [7:0] LVL_CTRL_MASK = 8'h37; // writable bits
  localparam logic [7:0] DUTY_MASK     = 8'hc0;
  localparam logic [1:0] PRL_OFF       = 2'h3;  // reset disabled, readable
  localparam logic [2:0] LTS_FIRST_OK  = 3'h4;  // lowest non-reserved code

  // ==========================================================================
  // timing
  localparam int SYS_PERIOD_NS  = 10;
  localparam int SLOW_PERIOD_NS = 31250;        // 32 kHz
  localparam int SLOW_HALF_CYC  = SLOW_PERIOD_NS / 2 / SYS_PERIOD_NS;
  localparam int DUTY_CNT_W     = 9;            // up to 1/512

  // ==========================================================================
  // sleep sequencer states
  typedef enum logic [3:0] {
    SWS_RUN,
    SWS_HALT_WAIT,
    SWS_PD_EDGE,
    SWS_ASLEEP,
    SWS_SYNC,
    SWS_POWER_UP,
    SWS_SAMPLE,
    SWS_RELEASE,
    SWS_GRANT_DROP
  } sws_state_t;

endpackage

// *** verilog/sws_slow_tick.sv ***
/*
 * sws_slow_tick: rebuilds the 32 kHz low-power clock as two one-cycle
 * enables, one for its rising and one for its falling edge.
 * assumes one free-running system clock and a synchronous active-low reset.
 */
module sws_slow_tick #(
  parameter int HALF_CYC = sws_pkg::SLOW_HALF_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  output logic      rise_o,
  output logic      fall_o
);

  initial
  begin
    if (HALF_CYC < 2 || HALF_CYC > 65535)
      $error("sws_slow_tick: HALF_CYC out of range");
  end

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        level_q;
  logic        level_d;
  logic        rise_q;
  logic        rise_d;
  logic        fall_q;
  logic        fall_d;

  // ==========================================================================
  // half-period counter; the level toggles at each wrap
  always_comb
  begin
    cnt_d   = cnt_q + 16'h0001;
    level_d = level_q;
    rise_d  = 1'b0;
    fall_d  = 1'b0;
    if (cnt_q == 16'(HALF_CYC - 1))
    begin
      cnt_d   = 16'h0000;
      level_d = ~level_q;
      rise_d  = ~level_q;
      fall_d  = level_q;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q   <= 16'h0000;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
    end
  end

  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule

// *** verification/sws_checker_properties.sv ***
/* sws_checker: port-level timing properties of the sleep/wake sequencer.
   assumes one system clock, synchronous active-low reset, bound below. */
module sws_checker #(
  parameter int SLOW_HALF_CYC = sws_pkg::SLOW_HALF_CYC
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        halt_request_o,
  input wire logic        halt_grant_i,
  input wire logic        wake_irq_i,
  input wire logic        power_down_line_o,
  input wire logic        flash_power_en_o,
  input wire logic        fast_osc_en_o,
  input wire logic        transient_filter_en_o,
  input wire logic        bandgap_en_o,
  input wire logic        monitor_on_o,
  input wire logic        precise_reset_flag_i,
  input wire logic [1:0]  precise_reset_level_o,
  input wire logic        precise_reset_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // slack of two cycles for the registered outputs
  localparam int WAKE_LO = SLOW_HALF_CYC - 1;
  localparam int WAKE_HI = 3 * SLOW_HALF_CYC + 4;
  localparam int REL_LO  = 3 * SLOW_HALF_CYC - 2;
  localparam int REL_HI  = 3 * SLOW_HALF_CYC + 2;
  logic sys_wr;
  logic sleep_wr;
  logic stop_q;

  // accepted write to the system control word
  assign sys_wr   = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                    && avs_address_i == {sws_pkg::SYS_CTRL_IDX, 2'b00};
  assign sleep_wr = sys_wr && avs_writedata_i[sws_pkg::SLEEP_BIT];

  // stop bit as last written; while it is set a sleeper must not wake
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      stop_q <= 1'b0;
    else if (sys_wr)
      stop_q <= avs_writedata_i[sws_pkg::STOP_BIT];
  end

  // ==========================================================================
  // properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sleep_halt: assert property (sleep_wr && !halt_request_o && !halt_grant_i && !power_down_line_o |-> ##[1:2] halt_request_o)
    else $error("halt request missing after sleep write");
  a_grant_pd: assert property ($rose(halt_grant_i) && halt_request_o |-> !power_down_line_o ##[1:2] power_down_line_o)
    else $error("power down not raised after grant");
  a_pd_cause: assert property ($rose(power_down_line_o) |-> halt_request_o && $past(halt_grant_i))
    else $error("power down without grant");
  a_domains_off: assert property ((flash_power_en_o == !power_down_line_o) && (fast_osc_en_o == !power_down_line_o)
    && (transient_filter_en_o == !power_down_line_o) && (bandgap_en_o == !power_down_line_o))
    else $error("power domains disagree with power down");
  a_wake_window: assert property ($rose(wake_irq_i) && power_down_line_o && !stop_q |-> ##[WAKE_LO:WAKE_HI] $fell(power_down_line_o))
    else $error("wake not in slow clock window");
  a_halt_release: assert property ($fell(power_down_line_o) |-> halt_request_o ##[REL_LO:REL_HI] $fell(halt_request_o))
    else $error("halt request release mistimed");
  a_precise_reset_flag_req: assert property ($past(rst_n_i) |-> precise_reset_req_o ==
    ($past(precise_reset_flag_i) && $past(precise_reset_level_o) != sws_pkg::PRL_OFF))
    else $error("precise reset request wrong");
  a_monitor_awake: assert property (!power_down_line_o && !$past(power_down_line_o) |-> monitor_on_o)
    else $error("monitor off while awake");
endmodule

bind sws_sleep_wake_supply_monitor sws_checker #(.SLOW_HALF_CYC(SLOW_HALF_CYC)) chk_u (.*);

// *** verification/sws_cpu_model.sv ***
/* sws_cpu_model: cpu core side of the halt handshake.
   assumes it shares the system clock; stall_i lengthens the running instruction. */
module sws_cpu_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       halt_request_i,
  input  wire logic [1:0] stall_i,
  output logic            halt_grant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;

  // grant only at an instruction boundary, so a stalled instruction delays it
  always @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      halt_grant_o <= 1'b0;
      wait_q       <= 2'h0;
    end
    else if (!halt_request_i)
    begin
      halt_grant_o <= 1'b0;
      wait_q       <= 2'h0;
    end
    else if (wait_q >= stall_i)
      halt_grant_o <= 1'b1;
    else
      wait_q <= wait_q + 2'h1;
  end
endmodule

// *** verification/sws_sleep_wake_supply_monitor_bench.sv ***
/* sws_sleep_wake_supply_monitor_bench: register, comparator and sleep/wake tests.
   assumes the checker is bound by its own file and the cpu model answers grants. */
module sws_sleep_wake_supply_monitor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         HALF = 8;
  localparam logic [9:0] SYS  = sws_pkg::SYS_CTRL_IDX;
  localparam logic [9:0] LVL  = sws_pkg::LVL_CTRL_IDX;
  localparam logic [9:0] CMP  = sws_pkg::CMP_STATE_IDX;
  localparam logic [9:0] DUTY = sws_pkg::DUTY_TRIM_IDX;
  localparam logic [9:0] STAT = sws_pkg::SEQ_STATUS_IDX;
  typedef struct packed { logic [9:0] idx; logic [7:0] wd; logic [7:0] ex; } sws_row_t;
  logic        sys_clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        halt_request_o, halt_grant_i, wake_irq_i, power_down_line_o, monitor_on_o;
  logic        flash_power_en_o, fast_osc_en_o, transient_filter_en_o, bandgap_en_o;
  logic        low_supply_flag_i, precise_reset_flag_i, precise_reset_req_o;
  logic [11:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic [1:0]  precise_reset_level_o, stall;
  logic [2:0]  lvd_trip_select_o;
  logic [7:0]  rd;
  logic [1:0]  woke;
  int          failures, num_checks;
  logic [9:0]  rst_idx [5] = '{SYS, LVL, CMP, DUTY, STAT};
  // writes with their read-back; reserved bits, read-only and unmapped places
  sws_row_t    rows [12] = '{'{LVL, 8'hff, 8'h37}, '{LVL, 8'h08, 8'h00}, '{LVL, 8'h04, 8'h04},
    '{LVL, 8'h15, 8'h15}, '{LVL, 8'h26, 8'h26}, '{LVL, 8'h33, 8'h33}, '{DUTY, 8'hff, 8'hc0},
    '{DUTY, 8'h40, 8'h40}, '{DUTY, 8'h80, 8'h80}, '{DUTY, 8'h00, 8'h00}, '{CMP, 8'hff, 8'h00},
    '{10'h100, 8'hff, 8'h00}};

  sws_sleep_wake_supply_monitor #(.SLOW_HALF_CYC(HALF)) dut_u (.*);
  sws_cpu_model cpu_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .halt_request_i(halt_request_o),
                       .stall_i(stall), .halt_grant_o(halt_grant_i));

  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  // one avalon access; waitrequest and read data are taken at the same rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] q);
    @(posedge sys_clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= {24'h0000_00, wd};
    do
    begin
      @(posedge sys_clk_i);
    end
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic reset_check();
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    chk("rst_pins", 8'h38, {halt_request_o, power_down_line_o, avs_waitrequest_o, monitor_on_o,
        flash_power_en_o, precise_reset_req_o, 2'b00});
    foreach (rst_idx[i])
    begin
      bus(1'b0, rst_idx[i], 8'h00, rd);
      chk("rst_reg", 8'h00, rd);
    end
  endtask

  // full sleep and wake; fl are the comparator levels at wake, stp sleeps with the stop bit set
  task automatic sleep_wake(input logic [1:0] st, input logic [1:0] fl, input logic stp);
    int n;
    int on;
    stall <= st;
    // firmware has parked usb pins, timer clocks and gpio before this write
    bus(1'b1, SYS, {7'h04, stp}, rd);
    n = 0;
    while (power_down_line_o !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (5) @(posedge sys_clk_i);
    chk("asleep", 8'h0c, {4'h0, halt_request_o, power_down_line_o, 1'b0, flash_power_en_o});
    bus(1'b0, STAT, 8'h00, rd);
    chk("state", {2'h0, woke, 4'h3}, rd);
    // duty 1/8: any eight slow periods hold exactly one on period
    on = 0;
    repeat (16 * HALF)
    begin
      @(posedge sys_clk_i);
      on += int'(monitor_on_o);
    end
    chk("duty_on", 8'(2 * HALF), 8'(on));
    {low_supply_flag_i, precise_reset_flag_i} <= fl;
    wake_irq_i <= 1'b1;
    // with the stop bit set the interrupt must not wake until stop is cleared
    if (stp)
    begin
      repeat (40) @(posedge sys_clk_i);
      chk("stop_hold", 8'h01, {7'h00, power_down_line_o});
      bus(1'b1, SYS, 8'h08, rd);
    end
    n = 0;
    while (halt_request_o !== 1'b0 && n < 200)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("woken", 8'h00, {7'h00, power_down_line_o});
    @(posedge sys_clk_i);
    wake_irq_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    bus(1'b0, SYS, 8'h00, rd);
    chk("sleep_bit", 8'h00, rd);
    bus(1'b0, STAT, 8'h00, rd);
    chk("wake_sample", {2'h0, fl, 4'h0}, rd);
    woke = fl;
    {low_supply_flag_i, precise_reset_flag_i} <= 2'b00;
  endtask

  task automatic finish_test();
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog and main sequence
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    finish_test();
  end

  initial
  begin
    failures = 0;
    num_checks = 0;
    woke = 2'b00;
    {rst_n_i, avs_read_i, avs_write_i, wake_irq_i, low_supply_flag_i, precise_reset_flag_i} = 6'h00;
    avs_address_i    = 12'h000;
    avs_writedata_i  = 32'h0000_0000;
    avs_byteenable_i = 4'hf;
    stall            = 2'h0;
    reset_check();
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].idx, rows[i].wd, rd);
      bus(1'b0, rows[i].idx, 8'h00, rd);
      chk("reg", rows[i].ex, rd);
      if (rows[i].idx == LVL)
        chk("lvl_pins", rows[i].ex, {2'h0, precise_reset_level_o, 1'b0, lvd_trip_select_o});
    end
    for (int i = 1; i < 4; i++)
    begin
      {low_supply_flag_i, precise_reset_flag_i} <= i[1:0];
      bus(1'b0, CMP, 8'h00, rd);
      chk("cmp", {6'h00, i[1:0]}, rd);
    end
    // a live precise-reset trip asks for a reset unless the level code is 11
    bus(1'b1, LVL, 8'h20, rd);
    repeat (2) @(posedge sys_clk_i);
    chk("preq_on", 8'h01, {7'h00, precise_reset_req_o});
    bus(1'b1, LVL, 8'h30, rd);
    repeat (2) @(posedge sys_clk_i);
    chk("preq_off", 8'h00, {7'h00, precise_reset_req_o});
    {low_supply_flag_i, precise_reset_flag_i} <= 2'b00;
    bus(1'b1, DUTY, 8'hc0, rd);
    sleep_wake(2'h0, 2'b10, 1'b0);
    sleep_wake(2'h2, 2'b01, 1'b1);
    reset_check();
    finish_test();
  end
endmodule
